// >>> rtl/afe_interrupt_flag_low_bits.sv
// Low thirteen interrupt status flags of the front end
`timescale 1ns/10ps
module afe_interrupt_flag_low_bits (
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clk_en,
    // Event sources
    input wire logic [3:0] custom_irq_set,
    input wire logic variance_done,
    input wire logic mean_done,
    input wire logic temperature_done,
    input wire logic second_filter_done,
    input wire logic fourier_done,
    input wire logic result_valid,
    input wire logic [15:0] result,
    // Limits
    input wire logic [15:0] successive_change_limit,
    input wire logic [15:0] upper_result_limit,
    input wire logic [15:0] lower_result_limit,
    // Clear mechanism, one bit per flag
    input wire logic [12:0] flag_clear,
    // Status
    output logic [12:0] flags,
    output logic [3:0] custom_irq_status,
    output logic variance_result_status,
    output logic mean_result_status,
    output logic delta_violation_status,
    output logic upper_limit_violation_status,
    output logic lower_limit_violation_status,
    output logic temperature_result_status,
    output logic second_filter_ready_status,
    output logic fourier_result_status,
    output logic conversion_result_status
);
    result_check_if chk_bus ();
    wire logic [12:0] set_event;
    logic [12:0] next_flags;

    assign chk_bus.result_valid = result_valid;
    assign chk_bus.result = result;
    assign chk_bus.upper_result_limit = upper_result_limit;
    assign chk_bus.lower_result_limit = lower_result_limit;
    assign chk_bus.successive_change_limit = successive_change_limit;

    result_limit_check u_check (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .clk_en(clk_en),
        .chk(chk_bus.checker_end)
    );

    assign set_event[irq_flag_pkg::BIT_CONVERSION] = result_valid;
    assign set_event[irq_flag_pkg::BIT_FOURIER] = fourier_done;
    assign set_event[irq_flag_pkg::BIT_SECOND_FILTER] =
        second_filter_done;
    assign set_event[irq_flag_pkg::BIT_TEMPERATURE] =
        temperature_done;
    assign set_event[irq_flag_pkg::BIT_LOWER_LIMIT] =
        chk_bus.under_lower;
    assign set_event[irq_flag_pkg::BIT_UPPER_LIMIT] =
        chk_bus.over_upper;
    assign set_event[irq_flag_pkg::BIT_DELTA] =
        chk_bus.delta_exceeded;
    assign set_event[irq_flag_pkg::BIT_MEAN] = mean_done;
    assign set_event[irq_flag_pkg::BIT_VARIANCE] = variance_done;
    assign set_event[12:9] = custom_irq_set;

    // Set beats clear so an event in the clearing cycle is never lost
    genvar i;
    generate
        for (i = 0; i < irq_flag_pkg::FLAG_W; i++) begin : g_flag
            assign next_flags[i] = set_event[i] |
                (flags[i] & ~flag_clear[i]);
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            flags <= irq_flag_pkg::FLAGS_RESET;
        end else if (clk_en) begin
            flags <= next_flags;
        end
    end

    assign custom_irq_status = flags[12:9];
    assign variance_result_status = flags[irq_flag_pkg::BIT_VARIANCE];
    assign mean_result_status = flags[irq_flag_pkg::BIT_MEAN];
    assign delta_violation_status = flags[irq_flag_pkg::BIT_DELTA];
    assign upper_limit_violation_status =
        flags[irq_flag_pkg::BIT_UPPER_LIMIT];
    assign lower_limit_violation_status =
        flags[irq_flag_pkg::BIT_LOWER_LIMIT];
    assign temperature_result_status = flags[irq_flag_pkg::BIT_TEMPERATURE];
    assign second_filter_ready_status =
        flags[irq_flag_pkg::BIT_SECOND_FILTER];
    assign fourier_result_status = flags[irq_flag_pkg::BIT_FOURIER];
    assign conversion_result_status = flags[irq_flag_pkg::BIT_CONVERSION];
endmodule

// >>> rtl/irq_flag_pkg.sv
// Package of bit positions, widths and reset values for the low flag bits
package irq_flag_pkg;
    localparam int FLAG_W = 13;
    localparam int RESULT_W = 16;
    localparam logic [12:0] FLAGS_RESET = 13'h0000;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam int BIT_CONVERSION = 0;
    localparam int BIT_FOURIER = 1;
    localparam int BIT_SECOND_FILTER = 2;
    localparam int BIT_TEMPERATURE = 3;
    localparam int BIT_LOWER_LIMIT = 4;
    localparam int BIT_UPPER_LIMIT = 5;
    localparam int BIT_DELTA = 6;
    localparam int BIT_MEAN = 7;
    localparam int BIT_VARIANCE = 8;
    localparam int BIT_CUSTOM_LO = 9;
    localparam int NUM_CUSTOM = 4;
endpackage

// >>> rtl/result_check_if.sv
// Interface carrying conversion results and limit-check outcomes
`timescale 1ns/10ps
interface result_check_if;
    logic result_valid;
    logic [15:0] result;
    logic [15:0] upper_result_limit;
    logic [15:0] lower_result_limit;
    logic [15:0] successive_change_limit;
    logic over_upper;
    logic under_lower;
    logic delta_exceeded;
    modport flags (output result_valid, output result,
        output upper_result_limit, output lower_result_limit,
        output successive_change_limit,
        input over_upper, input under_lower, input delta_exceeded);
    modport checker_end (input result_valid, input result,
        input upper_result_limit, input lower_result_limit,
        input successive_change_limit,
        output over_upper, output under_lower, output delta_exceeded);
endinterface

// >>> rtl/result_limit_check.sv
// Compares each conversion result against limits and the previous result
`timescale 1ns/10ps
module result_limit_check (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clk_en,
    // Results and outcomes
    result_check_if.checker_end chk
);
    logic [15:0] prev_result;
    logic have_prev;
    wire logic [15:0] change;

    // No delta check on the very first result: there is nothing to compare
    assign change = (chk.result >= prev_result) ?
        16'(chk.result - prev_result) : 16'(prev_result - chk.result);
    assign chk.over_upper = chk.result_valid &&
        (chk.result > chk.upper_result_limit);
    assign chk.under_lower = chk.result_valid &&
        (chk.result < chk.lower_result_limit);
    assign chk.delta_exceeded = chk.result_valid && have_prev &&
        (change > chk.successive_change_limit);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            prev_result <= irq_flag_pkg::RESULT_RESET;
            have_prev <= 1'b0;
        end else if (clk_en && chk.result_valid) begin
            prev_result <= chk.result;
            have_prev <= 1'b1;
        end
    end
endmodule

// >>> tb/flag_low_properties.sv
// Concurrent checks on the low interrupt flag outputs
`timescale 1ns/10ps
module flag_low_properties (
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clk_en,
    // Results, limits, clears and status
    input wire logic result_valid,
    input wire logic [15:0] result,
    input wire logic [15:0] upper_result_limit,
    input wire logic [15:0] lower_result_limit,
    input wire logic [12:0] flag_clear,
    input wire logic [12:0] flags
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    a_conv_set: assert property (
        clk_en && result_valid |=> flags[0])
        else $error("conversion flag not set");
    a_upper_set: assert property (clk_en && result_valid &&
        result > upper_result_limit ##1 1 |-> flags[5]) else $error("upper");
    a_lower_set: assert property (clk_en && result_valid &&
        result < lower_result_limit |=> flags[4]) else $error("lower");
    a_delta_hold: assert property (
        flags[6] && !flag_clear[6] |=> flags[6])
        else $error("delta flag dropped");
    a_lower_hold: assert property (
        flags[4] && !flag_clear[4] |=> flags[4])
        else $error("lower flag dropped");
    a_frozen_off: assert property (!clk_en |=> $stable(flags))
        else $error("flags moved while disabled");
    a_clear_works: assert property (clk_en && flag_clear[0] &&
        !result_valid |=> !flags[0]) else $error("clear ignored");
    a_upper_quiet: assert property (clk_en && flag_clear[5] &&
        !result_valid |=> !flags[5]) else $error("upper flag stuck");
    c_upper: cover property (result_valid && result > upper_result_limit);
    c_frozen: cover property (!clk_en && flags != 13'h0000);
    c_clear: cover property (clk_en && flag_clear != 13'h0000);
endmodule
bind afe_interrupt_flag_low_bits flag_low_properties props_inst (
    .sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en), .result(result),
    .result_valid(result_valid), .upper_result_limit(upper_result_limit),
    .lower_result_limit(lower_result_limit), .flag_clear(flag_clear),
    .flags(flags));

// >>> tb/flag_host_model.sv
// Host-side model that clears the flags it has read
`timescale 1ns/10ps
module flag_host_model (
    // Status seen and clear request
    input wire logic [12:0] flags,
    input wire logic [12:0] clr_mask,
    output logic [12:0] flag_clear
);
    // Clears only bits read as set, so a later event is never lost
    assign flag_clear = flags & clr_mask;
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the low interrupt flags
`timescale 1ns/10ps
module tb_top;
    logic sys_clk = 1'b0, nrst = 1'b0, clk_en = 1'b1, result_valid = 1'b0;
    logic [12:0] ev = '0, mask = '0;
    logic [15:0] res = '0, up = 16'hffff, lo = '0, dl = 16'h0010;
    wire [12:0] st, clr, fl;
    int mismatches = 0, n_checks = 0;
    always #10 sys_clk = ~sys_clk;
    afe_interrupt_flag_low_bits afe_interrupt_flag_low_bits_inst (
        .sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en),
        .custom_irq_set(ev[12:9]), .variance_done(ev[8]), .mean_done(ev[7]),
        .temperature_done(ev[3]), .second_filter_done(ev[2]),
        .fourier_done(ev[1]), .result_valid(result_valid), .result(res),
        .successive_change_limit(dl), .upper_result_limit(up),
        .lower_result_limit(lo), .flag_clear(clr), .flags(fl),
        .custom_irq_status(st[12:9]), .variance_result_status(st[8]),
        .mean_result_status(st[7]), .delta_violation_status(st[6]),
        .upper_limit_violation_status(st[5]),
        .lower_limit_violation_status(st[4]),
        .temperature_result_status(st[3]),
        .second_filter_ready_status(st[2]),
        .fourier_result_status(st[1]), .conversion_result_status(st[0]));
    flag_host_model flag_host_model_inst (.flags(fl), .clr_mask(mask),
        .flag_clear(clr));
    task check(input logic [12:0] got, input logic [12:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %0t flags %h expected %h", $time, got, exp);
        end
    endtask
    task step;
        @(posedge sys_clk);
        #1;
    endtask
    task conv(input logic [15:0] r, input logic [12:0] m);
        res = r;
        mask = m;
        result_valid = 1;
        step;
        result_valid = 0;
        mask = '0;
    endtask
    task t_events;
        for (int i = 1; i < 13; i++) begin
            if (i > 3 && i < 7) continue;
            ev = 13'h0001 << i;
            step;
            ev = '0;
            check(st, 13'h0001 << i);
            mask = 13'h1fff;
            step;
            mask = '0;
            check(fl, '0);
        end
    endtask
    task t_limits;
        up = 16'h0032;
        lo = 16'h000a;
        conv(16'h0064, '0);
        check(fl, 13'h0021);
        conv(16'h0005, '0);
        check(fl, 13'h0071);
        check(st, 13'h0071);
        up = 16'h000a;
        conv(16'h000a, 13'h1fff);
        check(fl, 13'h0001);
    endtask
    task t_hold;
        conv(16'h0005, 13'h1fff);
        check(fl, 13'h0011);
        conv(16'h000a, 13'h0001);
        check(fl, 13'h0011);
        clk_en = 1'b0;
        conv(16'h0005, 13'h1fff);
        clk_en = 1'b1;
        check(fl, 13'h0011);
        conv(16'h000a, 13'h1fff);
        check(fl, 13'h0001);
    endtask
    // Mid-run reset must also forget the previous result
    task t_reset;
        conv(16'h0064, 13'h0000);
        check(fl, 13'h0061);
        nrst = 1'b0;
        step;
        check(fl, 13'h0000);
        nrst = 1'b1;
        conv(16'h0005, 13'h0000);
        check(fl, 13'h0011);
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (6) step;
        nrst = 1;
        check(fl, '0);
        t_events;
        t_limits;
        t_hold;
        t_reset;
        final_report;
    end
endmodule
